// [hw/burst_sram_pkg.sv]
// Shared constants for the pipelined burst static memory port
package burst_sram_pkg;

  // ------------------------------------------------------------------
  // Geometry defaults
  // ------------------------------------------------------------------
  localparam int ADDR_W_DEF = 20;   // Word address width
  localparam int LANES_DEF  = 4;    // Byte lanes per word
  localparam int BYTE_W     = 8;    // Data bits per lane, plus one parity
  localparam int BURST_W    = 2;    // Address bits walked by a burst

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;          // 200 MHz ref_clk
  localparam int SLEEP_TCYC    = 2;             // Entry and exit, in cycles
  localparam int SLEEP_PS      = SLEEP_TCYC * CLK_PERIOD_PS;
  localparam logic [1:0] SLEEP_CYCLES =
    2'((SLEEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ------------------------------------------------------------------
  // Reset values and buffer size
  // ------------------------------------------------------------------
  localparam logic [1:0] BUF_ENTRIES = 2'h2;    // Write commit buffer
  localparam logic [1:0] CNT_RESET   = 2'h0;

  // Low-power state machine
  typedef enum logic [1:0] {
    PWR_AWAKE  = 2'b00,
    PWR_ENTER  = 2'b01,
    PWR_ASLEEP = 2'b10,
    PWR_LEAVE  = 2'b11
  } pwr_state_e;

endpackage

// [hw/burst_sram_port.sv]
// Pipelined burst static memory with back-to-back read and write
`timescale 1ns/1ps
// Operation
// - Gated clock edge is ignored; pipeline and burst state hold, but the commit buffer still drains.
// - Load with all selects active and write strobe high starts a read.
// - Read data leaves the output register one edge after address.
// - Data and parity drive only while output enable is low.
// - A new operation is accepted on every edge, no wait states.
// - Deselect at an edge floats outputs after the following edge.
// - Burst counter gives up to four reads from one address.
// - Burst order strap low is linear, high is interleaved.
// - Burst changes only the two low address bits, wrapping.
// - Advance moves the counter and ignores selects and write strobe.
// - Direction is taken at load and kept for the whole burst.
// - Load with all selects active and write strobe low starts a write.
// - Edge after write address floats outputs whatever output enable.
// - Write data is taken at the second edge after address.
// - Only selected byte lanes are updated by a write.
// - Burst writes give up to four beats, counter advancing each.
// - Sleep request enters or leaves sleep in two cycles; data kept.
// - Interleaved order is start XOR beat count.
// - Linear order counts the low bits up modulo four.
// - Strap left unconnected behaves as high.
// - Power-up leaves the port deselected with pins floating.
module burst_sram_port #(
  parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEF,
  parameter int LANES  = burst_sram_pkg::LANES_DEF
) (
  input  wire logic                               ref_clk,
  input  wire logic                               rst_n,
  input  wire logic                               clk_gate_n,
  input  wire logic                               chip_select_1_n,
  input  wire logic                               chip_select_2,
  input  wire logic                               chip_select_3_n,
  input  wire logic                               advance_load_n,
  input  wire logic                               write_en_n,
  input  wire logic                               out_en_n,
  input  wire logic                               sleep_req,
  input  wire logic                               burst_order,
  input  wire logic [LANES-1:0]                   byte_lane_sel_n,
  input  wire logic [ADDR_W-1:0]                  addr,
  input  wire logic [LANES*burst_sram_pkg::BYTE_W-1:0] data_in,
  output logic      [LANES*burst_sram_pkg::BYTE_W-1:0] data_out,
  output logic                                    data_oe,
  input  wire logic [LANES-1:0]                   parity_in,
  output logic      [LANES-1:0]                   parity_out,
  output logic                                    parity_oe
);

  localparam int DW   = LANES * burst_sram_pkg::BYTE_W;
  localparam int BW   = burst_sram_pkg::BURST_W;
  localparam int IN_W = 9 + LANES + ADDR_W + DW + LANES;

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < BW + 1 || ADDR_W > 24)
    $error("ADDR_W must lie between 3 and 24");
  if (LANES < 1 || LANES > 8)
    $error("LANES must lie between 1 and 8");

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------------
  logic            rst_meta_n;
  logic            rst_sync_n;
  logic [IN_W-1:0] pin_meta;
  logic [IN_W-1:0] pin_s;

  // Reset asserts at once and releases two edges later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Every pin passes two flops; the whole port lags its pins alike
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else begin
      pin_meta <= {clk_gate_n, chip_select_1_n, chip_select_2,
                   chip_select_3_n, advance_load_n, write_en_n, out_en_n,
                   sleep_req, burst_order, byte_lane_sel_n, addr,
                   data_in, parity_in};
      pin_s    <= pin_meta;
    end
  end

  logic              gate_s, cs1_s, cs2_s, cs3_s, adv_s, we_s, oe_s;
  logic              sleep_s, order_s;
  logic [LANES-1:0]  lanes_s, par_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DW-1:0]     din_s;
  assign {gate_s, cs1_s, cs2_s, cs3_s, adv_s, we_s, oe_s, sleep_s, order_s,
          lanes_s, addr_s, din_s, par_s} = pin_s;

  // ------------------------------------------------------------------
  // Burst order strap
  // ------------------------------------------------------------------
  logic interleave;

  // Sampled on every edge after release; a floating pin is pulled high on board
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) interleave <= 1'b1;
    else             interleave <= order_s;
  end

  // ------------------------------------------------------------------
  // Sleep control
  // ------------------------------------------------------------------
  burst_sram_pkg::pwr_state_e pwr;
  logic [1:0]                 pwr_cnt;
  logic                       awake;

  // Two cycles to settle either way; accesses are cut off on entry
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwr     <= burst_sram_pkg::PWR_AWAKE;
      pwr_cnt <= burst_sram_pkg::CNT_RESET;
    end else begin
      case (pwr)
        burst_sram_pkg::PWR_AWAKE: begin
          pwr_cnt <= burst_sram_pkg::CNT_RESET;
          if (sleep_s) pwr <= burst_sram_pkg::PWR_ENTER;
        end
        burst_sram_pkg::PWR_ENTER: begin
          pwr_cnt <= pwr_cnt + 2'h1;
          if (pwr_cnt == burst_sram_pkg::SLEEP_CYCLES - 2'h1) begin
            pwr     <= burst_sram_pkg::PWR_ASLEEP;
            pwr_cnt <= burst_sram_pkg::CNT_RESET;
          end
        end
        burst_sram_pkg::PWR_ASLEEP: begin
          if (!sleep_s) pwr <= burst_sram_pkg::PWR_LEAVE;
        end
        default: begin
          pwr_cnt <= pwr_cnt + 2'h1;
          if (pwr_cnt == burst_sram_pkg::SLEEP_CYCLES - 2'h1) begin
            pwr     <= burst_sram_pkg::PWR_AWAKE;
            pwr_cnt <= burst_sram_pkg::CNT_RESET;
          end
        end
      endcase
    end
  end
  assign awake = (pwr == burst_sram_pkg::PWR_AWAKE);

  // ------------------------------------------------------------------
  // Edge qualification and command decode
  // ------------------------------------------------------------------
  logic [1:0] buf_cnt;
  logic       buf_ready, en, load, sel;

  // A full commit buffer stalls the port like a gated edge
  assign buf_ready = (buf_cnt != burst_sram_pkg::BUF_ENTRIES);
  assign en   = !gate_s && awake && buf_ready;
  assign load = !adv_s;
  assign sel  = !cs1_s && cs2_s && !cs3_s;

  // ------------------------------------------------------------------
  // Burst counter and address stage
  // ------------------------------------------------------------------
  logic              burst_live, burst_write;
  logic [ADDR_W-1:0] burst_base;
  logic [BW-1:0]     burst_cnt, next_cnt, step_low;
  logic              s1_valid, s1_write, s2_valid, s2_write;
  logic [ADDR_W-1:0] s1_addr, s2_addr;
  logic [LANES-1:0]  s1_lanes, s2_lanes;

  assign next_cnt = burst_cnt + 2'h1;
  // Interleave flips bits, linear adds; only the low pair moves
  assign step_low = interleave ? (burst_base[BW-1:0] ^ next_cnt)
                               : (burst_base[BW-1:0] + next_cnt);

  // Load captures address and direction; advance walks the burst
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      burst_live  <= 1'b0;
      burst_write <= 1'b0;
      burst_base  <= '0;
      burst_cnt   <= burst_sram_pkg::CNT_RESET;
      s1_valid    <= 1'b0;
      s1_write    <= 1'b0;
      s1_addr     <= '0;
      s1_lanes    <= '0;
    end else if (!awake) begin
      burst_live <= 1'b0;
      s1_valid   <= 1'b0;
    end else if (en) begin
      s1_lanes <= lanes_s;
      if (load) begin
        burst_live  <= sel;
        burst_write <= !we_s;
        burst_base  <= addr_s;
        burst_cnt   <= burst_sram_pkg::CNT_RESET;
        s1_valid    <= sel;
        s1_write    <= !we_s;
        s1_addr     <= addr_s;
      end else begin
        // Selects and write strobe are not looked at here
        burst_cnt <= next_cnt;
        s1_valid  <= burst_live;
        s1_write  <= burst_write;
        s1_addr   <= {burst_base[ADDR_W-1:BW], step_low};
      end
    end
  end

  // Data stage follows the address stage on each taken edge
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s2_valid <= 1'b0;
      s2_write <= 1'b0;
      s2_addr  <= '0;
      s2_lanes <= '0;
    end else if (!awake) begin
      s2_valid <= 1'b0;
    end else if (en) begin
      s2_valid <= s1_valid;
      s2_write <= s1_write;
      s2_addr  <= s1_addr;
      s2_lanes <= s1_lanes;
    end
  end

  // ------------------------------------------------------------------
  // Storage, write commit buffer and forwarding
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] buf_addr  [0:1];
  logic [LANES-1:0]  buf_lanes [0:1];
  logic [DW-1:0]     buf_data  [0:1];
  logic [LANES-1:0]  buf_par   [0:1];
  logic              buf_wr, buf_rd, push, pop, hit;
  logic [DW-1:0]     fetch_d;
  logic [LANES-1:0]  fetch_p;

  // Beat data lands in the second edge after its address
  assign push = en && s2_valid && s2_write;
  // The core stops committing while asleep, but pushes need en and stop too, so the buffer never fills
  assign pop  = (buf_cnt != 2'h0) && awake;
  assign hit  = pop && (buf_addr[buf_rd] == s1_addr);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      buf_wr  <= 1'b0;
      buf_rd  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push) buf_wr <= !buf_wr;
      if (pop)  buf_rd <= !buf_rd;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Buffer storage carries no reset; only the pointers need one
  always_ff @(posedge ref_clk) begin
    if (push) begin
      buf_addr[buf_wr]  <= s2_addr;
      buf_lanes[buf_wr] <= ~s2_lanes;
      buf_data[buf_wr]  <= din_s;
      buf_par[buf_wr]   <= par_s;
    end
  end

  // Per lane: commit the head word, and forward it to a read in flight.
  // Each lane owns its array, so no two processes write one memory.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    localparam int LO = i * burst_sram_pkg::BYTE_W;
    logic [burst_sram_pkg::BYTE_W-1:0] mem_d [0:(1<<ADDR_W)-1];
    logic                              mem_p [0:(1<<ADDR_W)-1];
    always_ff @(posedge ref_clk) begin
      if (pop && buf_lanes[buf_rd][i]) begin
        mem_d[buf_addr[buf_rd]] <=
          buf_data[buf_rd][LO +: burst_sram_pkg::BYTE_W];
        mem_p[buf_addr[buf_rd]] <= buf_par[buf_rd][i];
      end
    end
    always_comb begin
      if (hit && buf_lanes[buf_rd][i]) begin
        fetch_d[LO +: burst_sram_pkg::BYTE_W] =
          buf_data[buf_rd][LO +: burst_sram_pkg::BYTE_W];
        fetch_p[i] = buf_par[buf_rd][i];
      end else begin
        fetch_d[LO +: burst_sram_pkg::BYTE_W] = mem_d[s1_addr];
        fetch_p[i] = mem_p[s1_addr];
      end
    end
  end

  // ------------------------------------------------------------------
  // Output register and drivers
  // ------------------------------------------------------------------
  logic drive, next_drive;

  // Reads drive; writes, deselects and sleep float the bus
  assign next_drive = !awake ? 1'b0
                    : en ? (s1_valid && !s1_write)
                    : drive;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      drive      <= 1'b0;
      data_oe    <= 1'b0;
      data_out   <= '0;
      parity_out <= '0;
    end else begin
      drive   <= next_drive;
      // Output enable is sampled, so it acts three edges after the pin
      data_oe <= next_drive && !oe_s;
      if (en && s1_valid && !s1_write) begin
        data_out   <= fetch_d;
        parity_out <= fetch_p;
      end
    end
  end
  assign parity_oe = data_oe;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  sequence read_load_s;
    en && load && sel && we_s;
  endsequence
  sequence write_load_s;
    en && load && sel && !we_s;
  endsequence

  gate_hold_a: assert property (!en && awake |=> $stable(burst_cnt)
    && $stable(s1_valid) && $stable(s1_addr))
    else $error("state moved on an ignored edge");
  read_drive_a: assert property (read_load_s ##1 (en && !oe_s)
    |=> data_oe && drive)
    else $error("read data not driven one edge after address");
  oe_float_a: assert property (oe_s |=> !data_oe)
    else $error("driving with output enable high");
  write_float_a: assert property (write_load_s ##1 en
    |=> !data_oe)
    else $error("driving after write address");
  deselect_a: assert property (en && load && !sel ##1 en
    |=> !data_oe)
    else $error("outputs active after deselect");
  cont_desel_a: assert property (en && !load && !burst_live
    |=> !s1_valid)
    else $error("access started after deselect");
  high_bits_a: assert property (en && !load && burst_live
    |=> s1_addr[ADDR_W-1:BW] == $past(burst_base[ADDR_W-1:BW]))
    else $error("burst changed upper address bits");
  order_seq_a: assert property (en && !load && burst_live
    |=> s1_addr[BW-1:0] == ($past(interleave)
      ? ($past(burst_base[BW-1:0]) ^ $past(next_cnt))
      : ($past(burst_base[BW-1:0]) + $past(next_cnt))))
    else $error("wrong burst sequence");
  dir_keep_a: assert property (en && !load && burst_live
    |=> s1_write == $past(burst_write))
    else $error("direction changed within burst");
  write_take_a: assert property (write_load_s ##1 en ##1 en
    |-> push)
    else $error("write data not taken on second edge");
  sleep_float_a: assert property (pwr == burst_sram_pkg::PWR_ASLEEP
    |-> !data_oe && !s1_valid)
    else $error("active while asleep");

endmodule

// [tb/sram_ctrl_model.sv]
// Memory controller model driving the port's pins and shared data bus
`timescale 1ns/1ps
module sram_ctrl_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] data_out,
  input  wire logic        data_oe,
  input  wire logic [3:0]  parity_out,
  output logic             clk_gate_n,
  output logic             chip_select_1_n,
  output logic             chip_select_2,
  output logic             chip_select_3_n,
  output logic             advance_load_n,
  output logic             write_en_n,
  output logic             out_en_n,
  output logic [3:0]       byte_lane_sel_n,
  output logic [9:0]       addr,
  output logic [31:0]      data_in,
  output logic [3:0]       parity_in
);
  logic [35:0] w1, w2, drv, last;
  logic        v1, v2, drv_en, live_wr;

  // ------------------------------------------------------------------
  // Bus level
  // ------------------------------------------------------------------
  // Released bus shows the inverse of its last level, never a held copy
  always_comb begin
    if (drv_en) {parity_in, data_in} = drv;
    else if (data_oe) {parity_in, data_in} = {parity_out, data_out};
    else {parity_in, data_in} = ~last;
  end

  // Last wire level, for the released-bus pattern
  always @(posedge ref_clk) last <= {parity_in, data_in};

  // Power-up: deselect load, nothing driven
  initial begin
    {w1, w2, drv, last} = '0;
    {v1, v2, drv_en, live_wr} = '0;
    step(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'hF, 10'h000, 36'h0);
  end

  // One cycle of pins; caller calls just after a falling edge
  task automatic step(input logic gate, ld_n, sel, we_n, oe_n,
                      input logic [3:0] ln, input logic [9:0] a,
                      input logic [35:0] w);
    clk_gate_n      = gate;
    advance_load_n  = ld_n;
    chip_select_1_n = !sel;
    chip_select_2   = sel;
    chip_select_3_n = !sel;
    write_en_n      = we_n;
    out_en_n        = oe_n;
    byte_lane_sel_n = ln;
    addr            = a;
    // A gated edge moves nothing, so the data pipeline waits too
    if (!gate) begin
      drv_en = v2;
      drv    = w2;
      v2     = v1;
      w2     = w1;
      if (!ld_n) live_wr = sel && !we_n;
      v1     = ld_n ? live_wr : (sel && !we_n);
      w1     = w;
    end
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------------
  // Rows: one cycle of pins and the output that cycle should produce
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  op;
    logic        oe_n;
    logic        md;
    logic [3:0]  ln;
    logic [9:0]  a;
    logic [31:0] w;
    logic        eo;
  } row_s;
  localparam logic [2:0] RD = 3'h0;
  localparam logic [2:0] WR = 3'h1;
  localparam logic [2:0] DS = 3'h2;
  localparam logic [2:0] AD = 3'h3;
  localparam logic [2:0] GT = 3'h4;
  localparam row_s DSR = '{DS,0,1,4'h0,10'h000,32'h0,0};
  localparam row_s ADR = '{AD,0,1,4'h0,10'h000,32'h0,1};
  localparam int NROW = 39;
  localparam row_s ROWS [NROW] = '{
    DSR, DSR,
    '{WR,0,0,4'h0,10'h041,32'hA0A0A001,0},
    '{AD,0,0,4'h0,10'h000,32'hA0A0A002,0},
    '{AD,0,0,4'h0,10'h000,32'hA0A0A003,0},
    '{AD,0,0,4'h0,10'h000,32'hA0A0A004,0},
    DSR,
    '{RD,0,0,4'h0,10'h043,32'hA0A0A003,1},
    '{AD,0,0,4'h0,10'h000,32'hA0A0A004,1},
    '{AD,0,0,4'h0,10'h000,32'hA0A0A001,1},
    '{AD,0,0,4'h0,10'h000,32'hA0A0A002,1},
    '{RD,0,1,4'h0,10'h042,32'hA0A0A002,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A003,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A004,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A001,1},
    '{RD,0,1,4'h0,10'h041,32'hA0A0A001,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A004,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A003,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A002,1},
    '{AD,0,1,4'h0,10'h000,32'hA0A0A001,1},
    DSR, DSR,
    '{WR,0,1,4'hA,10'h041,32'h55667788,0},
    '{AD,0,1,4'hF,10'h000,32'hFFFFFFFF,0},
    '{RD,0,1,4'h0,10'h043,32'hA0A0A003,1},
    '{RD,0,1,4'h0,10'h041,32'hA066A088,1},
    '{RD,0,1,4'h0,10'h040,32'hA0A0A004,1},
    DSR,
    '{AD,0,1,4'h0,10'h000,32'h0,0},
    '{AD,0,1,4'h0,10'h000,32'h0,0},
    '{RD,0,1,4'h0,10'h043,32'hA0A0A003,0},
    '{DS,1,1,4'h0,10'h000,32'h0,0},
    DSR,
    '{RD,0,1,4'h0,10'h040,32'hA0A0A004,1},
    '{GT,0,1,4'h0,10'h000,32'h0,0},
    '{GT,0,1,4'h0,10'h000,32'h0,0},
    '{AD,0,1,4'h0,10'h000,32'hA066A088,1},
    DSR, DSR
  };

  logic        ref_clk, rst_n, sleep_req, burst_order;
  logic        clk_gate_n, chip_select_1_n, chip_select_2, chip_select_3_n;
  logic        advance_load_n, write_en_n, out_en_n, data_oe, parity_oe;
  logic [3:0]  byte_lane_sel_n, parity_in, parity_out;
  logic [9:0]  addr;
  logic [31:0] data_in, data_out;
  logic [36:0] q[$];
  logic [36:0] prev, last_e;
  int          err_count, tests_run;

  // ------------------------------------------------------------------
  // Design, controller and clock
  // ------------------------------------------------------------------
  burst_sram_port #(.ADDR_W(10), .LANES(4)) dut (
    .ref_clk, .rst_n, .clk_gate_n, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .advance_load_n, .write_en_n, .out_en_n, .sleep_req,
    .burst_order, .byte_lane_sel_n, .addr, .data_in, .data_out, .data_oe,
    .parity_in, .parity_out, .parity_oe
  );
  sram_ctrl_model ctl (
    .ref_clk, .data_out, .data_oe, .parity_out, .clk_gate_n,
    .chip_select_1_n, .chip_select_2, .chip_select_3_n, .advance_load_n,
    .write_en_n, .out_en_n, .byte_lane_sel_n, .addr, .data_in, .parity_in
  );

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // Parity of a lane depends on that lane only, so merges stay exact
  function automatic logic [3:0] par_of(input logic [31:0] w);
    return {w[24], w[16], w[8], w[0]} ^ 4'h5;
  endfunction

  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One cycle: check the output due now, drive the row, queue its answer.
  // Pins pass two sync flops, so an answer shows four cycles later.
  task automatic run_row(input row_s r);
    logic [36:0] e;
    @(negedge ref_clk);
    if (q.size() == 3) begin
      e = q.pop_front();
      chk(37'({data_oe, parity_oe}), 37'({2{e[36]}}));
      if (e[36] === 1'h1)
        chk(37'({parity_out, data_out}), {1'h0, e[35:0]});
    end
    burst_order = r.md;
    ctl.step(r.op == GT, r.op == AD, r.op == RD || r.op == WR,
             !(r.op == WR || r.op == AD), r.oe_n, r.ln, r.a,
             {par_of(r.w), r.w});
    chk(37'(ctl.drv_en & data_oe), 37'h0);
    if (r.op == GT) begin
      q.push_back(last_e);
    end else begin
      q.push_back(prev);
      last_e = prev;
      prev   = {r.eo, par_of(r.w), r.w};
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    ref_clk     = 1'h0;
    rst_n       = 1'h0;
    sleep_req   = 1'h0;
    burst_order = 1'h1;
    err_count   = 0;
    tests_run   = 0;
    prev        = '0;
    last_e      = '0;
    repeat (8) @(negedge ref_clk);
    chk(37'({data_oe, parity_oe}), 37'h0);
    repeat (8) @(negedge ref_clk);
    rst_n = 1'h1;
    $display("test power-up done");
    for (int i = 0; i < NROW; i++) run_row(ROWS[i]);
    $display("test table done");
    // Reset lands while a burst is being read out
    run_row('{RD,0,1,4'h0,10'h040,32'hA0A0A004,1});
    repeat (3) run_row(ADR);
    @(negedge ref_clk);
    chk(37'(data_oe), 37'h1);
    rst_n = 1'h0;
    #1;
    chk(37'(data_oe), 37'h0);
    repeat (16) @(negedge ref_clk);
    rst_n = 1'h1;
    q.delete();
    prev   = '0;
    last_e = '0;
    $display("test reset done");
    // Sleep with the port deselected, then read back stored data
    repeat (4) run_row(DSR);
    sleep_req = 1'h1;
    repeat (10) run_row(DSR);
    sleep_req = 1'h0;
    repeat (8) run_row(DSR);
    run_row('{RD,0,1,4'h0,10'h041,32'hA066A088,1});
    repeat (4) run_row(DSR);
    $display("test sleep done");
    tally_and_finish();
  end

  // Hang guard: overstaying counts as a mismatch
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
